/* include/fpcs_pkg.sv */
// Shared constants and types for the flash program/erase command sequencer host
package fpcs_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int PULSE_NS      = 10000;  // Program pulse interval
   localparam int RECOV_NS      = 6000;   // Write recovery before verify read
   localparam int RAMP_NS       = 100;    // Program supply settle before commands
   localparam int ERASE_US      = 10000;  // Erase pulse interval
   // Least times round up to whole cycles
   localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOV_CYC = (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAMP_CYC  = (RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_CYC = (ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = 4;         // Strobe low time, covers access plus input sync

   // ==========================================================
   // Retry limits and geometry
   localparam int MAX_PROG_PULSES  = 25;
   localparam int MAX_ERASE_PULSES = 1000;
   localparam int ADDR_W           = 16;
   localparam int DLY_W            = 18;
   localparam int PCNT_W           = 10;

   // ==========================================================
   // Command codes written to the device, erased byte value and identification addresses
   localparam logic [7:0] CMD_READ         = 8'h00;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
   localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
   localparam logic [7:0] CMD_IDENT        = 8'h90;
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'ha0;
   localparam logic [7:0] CMD_PROG_VERIFY  = 8'hc0;
   localparam logic [7:0] CMD_RESET        = 8'hff;
   localparam logic [7:0] ERASED_BYTE      = 8'hff;
   localparam logic [15:0] ID_MAKER_ADDR   = 16'h0000;
   localparam logic [15:0] ID_DEVICE_ADDR  = 16'h0001;

   // ==========================================================
   // User operations
   typedef enum logic [2:0] {
      OP_READ    = 3'h0,
      OP_PROGRAM = 3'h1,
      OP_ERASE   = 3'h2,
      OP_IDENT   = 3'h3,
      OP_RESET   = 3'h4
   } fpcs_op_t;

endpackage

/* hdl/fpcs_bus_cycle.sv */
// One flash pin cycle: write with address on falling and data on rising strobe, or read
`timescale 1ns/1ps
module fpcs_bus_cycle #(
   parameter int ADDR_W     = 16,
   parameter int STROBE_CYC = 4
)(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   // Request from sequencer
   input  wire logic              start_i,
   input  wire logic              write_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [7:0]        data_i,
   output      logic              busy_o,
   output      logic              done_o,
   output      logic [7:0]        rdata_o,
   // Flash pins
   output      logic [ADDR_W-1:0] fl_addr_o,
   output      logic [7:0]        fl_dq_o,
   output      logic              fl_dq_oe_o,
   input  wire logic [7:0]        fl_dq_i,
   output      logic              fl_ce_n_o,
   output      logic              fl_we_n_o,
   output      logic              fl_oe_n_o
);

   // ==========================================================
   // Cycle state
   typedef enum logic [1:0] {
      B_IDLE   = 2'b00,
      B_SETUP  = 2'b01,
      B_STROBE = 2'b10,
      B_HOLD   = 2'b11
   } fpcs_bus_state_t;

   fpcs_bus_state_t state;
   fpcs_bus_state_t next_state;
   logic [3:0]      cnt;
   logic            is_write;
   logic [7:0]      dq_meta;
   logic [7:0]      dq_sync;

   wire strobe_last = (cnt == 4'(STROBE_CYC - 1));

   // Next state decode
   always_comb
   begin
      case (state)
         B_IDLE:   next_state = start_i ? B_SETUP : B_IDLE;
         B_SETUP:  next_state = B_STROBE;
         B_STROBE: next_state = strobe_last ? B_HOLD : B_STROBE;
         B_HOLD:   next_state = B_IDLE;
         default:  next_state = B_IDLE;
      endcase
   end

   assign busy_o = (state != B_IDLE);
   assign done_o = (state == B_HOLD);

   // Data pins come from another domain, two stages before use
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dq_meta <= 8'h00;
         dq_sync <= 8'h00;
      end
      else
      begin
         dq_meta <= fl_dq_i;
         dq_sync <= dq_meta;
      end
   end

   // State, strobe counter and read capture
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state   <= B_IDLE;
         cnt     <= 4'h0;
         rdata_o <= 8'h00;
      end
      else
      begin
         state <= next_state;
         cnt   <= (state == B_STROBE) ? cnt + 4'h1 : 4'h0;
         if (state == B_STROBE && strobe_last && !is_write)
            rdata_o <= dq_sync;
      end
   end

   // Pins are registered; address is stable before the strobe falls, data past its rise
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         is_write   <= 1'b0;
         fl_addr_o  <= '0;
         fl_dq_o    <= 8'h00;
         fl_dq_oe_o <= 1'b0;
         fl_ce_n_o  <= 1'b1;
         fl_we_n_o  <= 1'b1;
         fl_oe_n_o  <= 1'b1;
      end
      else
      begin
         if (state == B_IDLE && start_i)
         begin
            is_write  <= write_i;
            fl_addr_o <= addr_i;
            fl_dq_o   <= data_i;
         end
         fl_ce_n_o  <= (next_state == B_IDLE);
         fl_dq_oe_o <= (next_state != B_IDLE) && (state == B_IDLE ? write_i : is_write);
         fl_we_n_o  <= !(next_state == B_STROBE && is_write);
         fl_oe_n_o  <= !(next_state == B_STROBE && !is_write);
      end
   end

endmodule

/* hdl/fpcs_host_sequencer.sv */
// Host-side sequencer that drives a command-register flash through its pins
// Notes on behaviour
// - Program setup code 40h, array untouched
// - Wait pulse interval before next command
// - Write C0h after pulse to verify
// - Wait recovery time before verify read
// - Compare readback, retry, 25 pulses maximum
// - Time erase pulses, erase-verify after each
// - After program setup, reset twice
// - Single reset suffices after other commands
// - Always issue reset twice in succession
// - Code 80h or 90h enters identification
// - Identification persists until another command
// - Mask finished erase with read command
`timescale 1ns/1ps
module fpcs_host_sequencer #(
   parameter int ADDR_W    = fpcs_pkg::ADDR_W,
   parameter int ERASE_CYC = fpcs_pkg::ERASE_CYC,
   parameter logic [ADDR_W-1:0] LAST_ADDR = '1
)(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   // User request
   input  wire logic              req_valid_i,
   output      logic              req_ready_o,
   input  wire logic [2:0]        req_op_i,
   input  wire logic [ADDR_W-1:0] req_addr_i,
   input  wire logic [7:0]        req_data_i,
   // User answer
   output      logic              resp_valid_o,
   output      logic [15:0]       resp_data_o,
   output      logic              resp_fail_o,
   // Flash pins
   output      logic [ADDR_W-1:0] fl_addr_o,
   output      logic [7:0]        fl_dq_o,
   output      logic              fl_dq_oe_o,
   input  wire logic [7:0]        fl_dq_i,
   output      logic              fl_ce_n_o,
   output      logic              fl_we_n_o,
   output      logic              fl_oe_n_o,
   output      logic              fl_vpp_high_o
);

   localparam int DLY_W  = fpcs_pkg::DLY_W;
   localparam int PCNT_W = fpcs_pkg::PCNT_W;

   // ==========================================================
   // Sequencer state
   typedef enum logic [3:0] {
      S_IDLE     = 4'h0,
      S_RAMP     = 4'h1,
      S_SETUP    = 4'h2,
      S_LOAD     = 4'h3,
      S_PULSE    = 4'h4,
      S_VERIFY   = 4'h5,
      S_RECOV    = 4'h6,
      S_READBACK = 4'h7,
      S_RESET1   = 4'h8,
      S_RESET2   = 4'h9,
      S_ID_CMD   = 4'ha,
      S_ID_RD    = 4'hb,
      S_RD_CMD   = 4'hc,
      S_RD       = 4'hd,
      S_MASK     = 4'he,
      S_DONE     = 4'hf
   } fpcs_state_t;

   fpcs_state_t       state;
   fpcs_state_t       next_state;
   fpcs_pkg::fpcs_op_t op;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        data;
   logic [DLY_W-1:0]  dwell;
   logic [PCNT_W-1:0] pulses;
   logic              launched;
   logic              id_idx;
   logic              cyc_busy;
   logic              cyc_done;
   logic [7:0]        cyc_rdata;
   logic [DLY_W-1:0]  wait_len;
   logic [7:0]        cyc_code;
   logic [ADDR_W-1:0] cyc_addr;

   // ==========================================================
   // Step decode: what each state puts on the pins
   wire is_prog   = (op == fpcs_pkg::OP_PROGRAM);
   wire bus_state = !(state inside {S_IDLE, S_RAMP, S_PULSE, S_RECOV, S_DONE});
   wire is_read   = (state inside {S_READBACK, S_ID_RD, S_RD});
   wire cyc_start = bus_state && !cyc_busy && !launched;
   wire wait_end  = (dwell == wait_len - 1'b1);
   wire match     = (cyc_rdata == data);
   wire erased    = (cyc_rdata == fpcs_pkg::ERASED_BYTE);
   wire [PCNT_W-1:0] pulse_max = is_prog ? PCNT_W'(fpcs_pkg::MAX_PROG_PULSES)
                                         : PCNT_W'(fpcs_pkg::MAX_ERASE_PULSES);

   // Codes and addresses per step; verify reuses the captured address
   always_comb
   begin
      cyc_code = fpcs_pkg::CMD_RESET;
      cyc_addr = addr;
      wait_len = DLY_W'(fpcs_pkg::RAMP_CYC);
      case (state)
         S_SETUP:  cyc_code = is_prog ? fpcs_pkg::CMD_PROG_SETUP : fpcs_pkg::CMD_ERASE_SETUP;
         S_LOAD:   cyc_code = is_prog ? data : fpcs_pkg::CMD_ERASE_SETUP;
         S_VERIFY: cyc_code = is_prog ? fpcs_pkg::CMD_PROG_VERIFY : fpcs_pkg::CMD_ERASE_VERIFY;
         S_ID_CMD: cyc_code = fpcs_pkg::CMD_IDENT;
         S_ID_RD:  cyc_addr = id_idx ? ADDR_W'(fpcs_pkg::ID_DEVICE_ADDR)
                                     : ADDR_W'(fpcs_pkg::ID_MAKER_ADDR);
         S_RD_CMD: cyc_code = fpcs_pkg::CMD_READ;
         S_MASK:   cyc_code = fpcs_pkg::CMD_READ;
         S_PULSE:  wait_len = is_prog ? DLY_W'(fpcs_pkg::PULSE_CYC) : DLY_W'(ERASE_CYC);
         S_RECOV:  wait_len = DLY_W'(fpcs_pkg::RECOV_CYC);
         default:  cyc_code = fpcs_pkg::CMD_RESET;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      next_state = state;
      case (state)
         S_IDLE:
            if (req_valid_i)
               case (req_op_i)
                  fpcs_pkg::OP_PROGRAM, fpcs_pkg::OP_ERASE: next_state = S_RAMP;
                  fpcs_pkg::OP_IDENT: next_state = S_ID_CMD;
                  fpcs_pkg::OP_READ:  next_state = S_RD_CMD;
                  default:            next_state = S_RESET1;
               endcase
         S_RAMP:   if (wait_end) next_state = S_SETUP;
         S_SETUP:  if (cyc_done) next_state = S_LOAD;
         S_LOAD:   if (cyc_done) next_state = S_PULSE;
         S_PULSE:  if (wait_end) next_state = S_VERIFY;
         S_VERIFY: if (cyc_done) next_state = S_RECOV;
         S_RECOV:  if (wait_end) next_state = S_READBACK;
         S_READBACK:
            if (cyc_done)
            begin
               if (is_prog ? match : erased)
                  next_state = is_prog ? S_RESET1 : (addr == LAST_ADDR ? S_MASK : S_VERIFY);
               else
                  next_state = (pulses == pulse_max) ? S_RESET1 : S_SETUP;
            end
         S_RESET1: if (cyc_done) next_state = S_RESET2;
         S_RESET2: if (cyc_done) next_state = S_DONE;
         S_ID_CMD: if (cyc_done) next_state = S_ID_RD;
         S_ID_RD:  if (cyc_done && id_idx) next_state = S_RESET1;
         S_RD_CMD: if (cyc_done) next_state = S_RD;
         S_RD:     if (cyc_done) next_state = S_DONE;
         S_MASK:   if (cyc_done) next_state = S_RESET1;
         S_DONE:   next_state = S_IDLE;
         default:  next_state = S_IDLE;
      endcase
   end

   assign req_ready_o  = (state == S_IDLE);
   assign resp_valid_o = (state == S_DONE);

   // Request capture, dwell timer and launch bookkeeping
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state    <= S_IDLE;
         op       <= fpcs_pkg::OP_READ;
         addr     <= '0;
         data     <= 8'h00;
         dwell    <= '0;
         launched <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         dwell    <= (next_state != state) ? '0 : dwell + 1'b1;
         launched <= cyc_done ? 1'b0 : (launched | cyc_start);
         if (state == S_IDLE && req_valid_i)
         begin
            op   <= fpcs_pkg::fpcs_op_t'(req_op_i);
            addr <= (req_op_i == fpcs_pkg::OP_ERASE) ? '0 : req_addr_i;
            data <= req_data_i;
         end
         else if (state == S_READBACK && cyc_done && !is_prog && erased && addr != LAST_ADDR)
            addr <= addr + 1'b1;   // Next erase-verify address
      end
   end

   // Pulse count, supply switch and answer; supply is high only around program/erase
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pulses        <= '0;
         id_idx        <= 1'b0;
         fl_vpp_high_o <= 1'b0;
         resp_data_o   <= 16'h0000;
         resp_fail_o   <= 1'b0;
      end
      else
      begin
         if (state == S_IDLE)
         begin
            pulses      <= '0;
            id_idx      <= 1'b0;
            resp_fail_o <= 1'b0;
         end
         if (state == S_LOAD && cyc_done)
            pulses <= pulses + 1'b1;
         fl_vpp_high_o <= (next_state inside {S_RAMP, S_SETUP, S_LOAD, S_PULSE, S_VERIFY,
                                              S_RECOV, S_READBACK, S_MASK});
         if (state == S_READBACK && cyc_done)
         begin
            resp_data_o <= {8'h00, cyc_rdata};
            resp_fail_o <= !(is_prog ? match : erased) && (pulses == pulse_max);
         end
         if ((state == S_ID_RD || state == S_RD) && cyc_done)
         begin
            if (id_idx)
               resp_data_o[15:8] <= cyc_rdata;
            else
               resp_data_o <= {8'h00, cyc_rdata};
            id_idx <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Pin cycle engine
   fpcs_bus_cycle #(
      .ADDR_W     (ADDR_W),
      .STROBE_CYC (fpcs_pkg::STROBE_CYC)
   ) u_cycle (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n_i),
      .start_i    (cyc_start),
      .write_i    (!is_read),
      .addr_i     (cyc_addr),
      .data_i     (cyc_code),
      .busy_o     (cyc_busy),
      .done_o     (cyc_done),
      .rdata_o    (cyc_rdata),
      .fl_addr_o  (fl_addr_o),
      .fl_dq_o    (fl_dq_o),
      .fl_dq_oe_o (fl_dq_oe_o),
      .fl_dq_i    (fl_dq_i),
      .fl_ce_n_o  (fl_ce_n_o),
      .fl_we_n_o  (fl_we_n_o),
      .fl_oe_n_o  (fl_oe_n_o)
   );

   // ==========================================================
   // Checks
   property p_setup_then_load;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state == S_SETUP && cyc_done) |=> (state == S_LOAD) && cyc_start && (!is_prog || cyc_code == data);
   endproperty
   a_setup_then_load: assert property (p_setup_then_load) else $error("setup not followed by load");

   property p_prog_pulse_len;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state == S_PULSE && next_state == S_VERIFY && is_prog) |-> (dwell == DLY_W'(fpcs_pkg::PULSE_CYC - 1));
   endproperty
   a_prog_pulse_len: assert property (p_prog_pulse_len) else $error("program pulse wait wrong");

   property p_erase_pulse_len;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state == S_PULSE && next_state == S_VERIFY && !is_prog) |-> (dwell == DLY_W'(ERASE_CYC - 1));
   endproperty
   a_erase_pulse_len: assert property (p_erase_pulse_len) else $error("erase pulse wait wrong");

   property p_recovery;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state == S_RECOV && next_state == S_READBACK) |-> (dwell == DLY_W'(fpcs_pkg::RECOV_CYC - 1));
   endproperty
   a_recovery: assert property (p_recovery) else $error("verify read before recovery");

   property p_pulse_limit;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state == S_LOAD && cyc_start) |-> (pulses < pulse_max);
   endproperty
   a_pulse_limit: assert property (p_pulse_limit) else $error("pulse limit exceeded");

   property p_double_reset;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state == S_RESET1 && cyc_done) |=> (state == S_RESET2) && cyc_start
                                          ##1 (!fl_ce_n_o && fl_dq_o == fpcs_pkg::CMD_RESET);
   endproperty
   a_double_reset: assert property (p_double_reset) else $error("reset not issued twice");

   property p_supply_high;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state inside {S_SETUP, S_LOAD, S_VERIFY} && cyc_start) |-> fl_vpp_high_o && $past(fl_vpp_high_o, 2);
   endproperty
   a_supply_high: assert property (p_supply_high) else $error("program step at low supply");

   property p_id_addr;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state == S_ID_RD && cyc_start) |-> (cyc_addr == ADDR_W'(id_idx)) ##2 (fl_addr_o == ADDR_W'(id_idx));
   endproperty
   a_id_addr: assert property (p_id_addr) else $error("identification address wrong");

   property p_mask_read;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state == S_READBACK && cyc_done && !is_prog && erased && addr == LAST_ADDR) |=> (state == S_MASK);
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("erase not masked");

   property p_strobe_idle;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state == S_IDLE) |-> fl_we_n_o && fl_oe_n_o && !fl_vpp_high_o;
   endproperty
   a_strobe_idle: assert property (p_strobe_idle) else $error("pins active while idle");

   c_prog_done:  cover property (@(posedge clock_i) disable iff (!rst_n_i) state == S_DONE && is_prog && !resp_fail_o);
   c_prog_retry: cover property (@(posedge clock_i) disable iff (!rst_n_i) state == S_SETUP && pulses == 2);
   c_erase_mask: cover property (@(posedge clock_i) disable iff (!rst_n_i) state == S_MASK);
   c_ident:      cover property (@(posedge clock_i) disable iff (!rst_n_i) state == S_ID_RD && cyc_done && id_idx);

endmodule

/* test/fpcs_flash_model.sv */
// Behavioural byte-wide command-register flash that answers the host sequencer
`timescale 1ns/1ps
module fpcs_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'h5a,   // Arbitrary identity value
   parameter logic [7:0] DEV_CODE   = 8'hc3,   // Arbitrary identity value
   parameter real        ERASE_NS   = 15000.0
)(
   // Pins from the host
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  dq_i,
   input  wire logic        ce_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        vpp_high_i,
   input  wire logic        dq_oe_i,
   // Pins to the host and fault count
   output      logic [7:0]  dq_o,
   output      int          viol_o
);
   typedef enum logic [2:0] {M_READ, M_PSET, M_PROG, M_PVER, M_ESET, M_EVER, M_IDENT} fpcs_mstate_t;
   logic [7:0]   mem [4];
   fpcs_mstate_t st = M_READ;           // Powers up in read mode
   logic [15:0]  lat_a = 16'h0000;
   logic [15:0]  ver_a = 16'h0000;
   logic [7:0]   drv;
   logic [7:0]   last_q = 8'h00;
   realtime      t_pulse = 0.0;
   realtime      t_ver = 0.0;
   realtime      need_ns = 0.0;
   int           prog_fails = 0;
   int           erase_fails = 0;
   int           pulses = 0;
   initial viol_o = 0;
   initial foreach (mem[i]) mem[i] = 8'hff;
   // Address latched on the falling strobe; a host that is early breaks the pulse time
   always @(negedge we_n_i)
   begin
      if (!ce_n_i)
      begin
         lat_a = addr_i;
         if ($realtime - t_pulse < need_ns) viol_o++;
         need_ns = 0.0;
      end
   end
   // Command decode on the rising strobe; low supply inhibits any array change
   always @(posedge we_n_i)
   begin
      if (!ce_n_i && st == M_PSET)
      begin
         ver_a = lat_a;
         t_pulse = $realtime;                                 // Pulse runs until the next command strobe ends it
         need_ns = fpcs_pkg::PULSE_NS;
         pulses++;
         if (prog_fails > 0) prog_fails--;
         else if (vpp_high_i) mem[lat_a[1:0]] &= dq_i;        // All ones is null data
         st = M_PROG;
      end
      else if (!ce_n_i && st == M_ESET && dq_i == 8'h20)
      begin
         t_pulse = $realtime;
         need_ns = ERASE_NS;
         if (erase_fails > 0) erase_fails--;
         else if (vpp_high_i) foreach (mem[i]) mem[i] = 8'hff;
         st = M_PROG;
      end
      else if (!ce_n_i)
      begin
         ver_a = (dq_i == 8'ha0) ? lat_a : ver_a;
         t_ver = $realtime;
         case (dq_i)
            8'h40: st = M_PSET;                               // Array untouched
            8'h20: st = M_ESET;
            8'hc0: st = M_PVER;
            8'ha0: st = M_EVER;
            8'h80, 8'h90: st = M_IDENT;
            default: st = M_READ;
         endcase
      end
   end
   // A read too soon after a verify command may see false data
   always @(negedge oe_n_i)
   begin
      if (!ce_n_i && (st == M_PVER || st == M_EVER) && $realtime - t_ver < fpcs_pkg::RECOV_NS) viol_o++;
   end
   assign drv = (st == M_IDENT) ? (addr_i[0] ? DEV_CODE : MAKER_CODE) :
                (st == M_PVER || st == M_EVER) ? mem[ver_a[1:0]] : mem[addr_i[1:0]];
   // Host must drive the data pins through each write strobe and release them for reads
   always @(negedge oe_n_i) if (!ce_n_i && dq_oe_i) viol_o++;
   always @(posedge we_n_i) if (!ce_n_i && !dq_oe_i) viol_o++;
   always @(posedge oe_n_i) last_q <= drv;
   // Released bus shows the inverse so a late sample cannot pass by luck
   assign dq_o = (!ce_n_i && !oe_n_i) ? drv : ~last_q;
endmodule

/* test/testbench.sv */
// Self-checking bench: host sequencer against the behavioural flash
`timescale 1ns/1ps
module testbench;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        req_valid_i = 1'b0;
   logic [2:0]  req_op_i = 3'h0;
   logic [15:0] req_addr_i = 16'h0000;
   logic [7:0]  req_data_i = 8'h00;
   logic        req_ready_o, resp_valid_o, resp_fail_o, dq_oe, ce_n, we_n, oe_n, vpp;
   logic [15:0] resp_data_o, fl_addr;
   logic [7:0]  fl_dq_o, fl_dq_i, b;
   logic [7:0]  shadow [4];
   logic [18:0] e;
   logic [18:0] exp_q [$];                     // {skip data, full word, fail, data}
   int          viol;
   int          err_total = 0;
   int          compares = 0;
   int          cycles = 0;
   fpcs_host_sequencer #(.ERASE_CYC(300), .LAST_ADDR(16'h0003)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i), .req_addr_i(req_addr_i),
      .req_data_i(req_data_i), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .resp_fail_o(resp_fail_o),
      .fl_addr_o(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n_o(ce_n),
      .fl_we_n_o(we_n), .fl_oe_n_o(oe_n), .fl_vpp_high_o(vpp));
   fpcs_flash_model #(.ERASE_NS(15000.0)) model_u (.addr_i(fl_addr), .dq_i(fl_dq_o), .ce_n_i(ce_n),
      .we_n_i(we_n), .oe_n_i(oe_n), .vpp_high_i(vpp), .dq_oe_i(dq_oe), .dq_o(fl_dq_i), .viol_o(viol));
   initial
   begin
      forever #25 clock_i = ~clock_i;
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] expv);
      compares++;
      if (seen !== expv)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
      end
   endtask
   task automatic stop_test();
      err_total += viol;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One user request; waits till its answer has been checked
   task automatic op(input logic [2:0] o, input logic [15:0] a, input logic [7:0] d, input logic [18:0] ex);
      exp_q.push_back(ex);
      @(negedge clock_i);
      req_op_i = o;
      req_addr_i = a;
      req_data_i = d;
      req_valid_i = 1'b1;
      do @(posedge clock_i); while (req_ready_o !== 1'b1);
      @(negedge clock_i);
      req_valid_i = 1'b0;
      req_op_i = 3'($urandom);                 // Noise while busy must not be taken
      while (exp_q.size() != 0) @(negedge clock_i);
   endtask
   // Answer watcher and hang limit; sized well above the longest run of 25 pulses
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         err_total++;
         stop_test();
      end
      if (rst_n_i && resp_valid_o === 1'b1)
      begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 19'h7ffff;
         chk("fail flag", {15'h0, resp_fail_o}, {15'h0, e[16]});
         if (!e[18]) chk("answer", e[17] ? resp_data_o : {8'h00, resp_data_o[7:0]}, e[15:0]);
      end
   end
   initial
   begin
      void'($urandom(32'h3a327b4f));
      repeat (6) @(negedge clock_i);
      chk("ready in reset", {14'h0, req_ready_o, resp_valid_o}, 16'h0002);
      rst_n_i = 1'b1;
      foreach (shadow[i]) shadow[i] = 8'hff;
      op(3'h0, 16'h0002, 8'h00, 19'h000ff);
      op(3'h3, 16'h0000, 8'h00, {3'b010, 8'hc3, 8'h5a});
      op(3'h0, 16'h0001, 8'h00, 19'h000ff);
      // Every address programmed, one of them needing retries
      for (int i = 0; i < 4; i++)
      begin
         b = 8'($urandom) & 8'hfe;
         shadow[i] = b;
         model_u.prog_fails = (i == 1) ? 2 : 0;
         model_u.pulses = 0;
         op(3'h1, 16'(i), b, {3'b000, 8'h00, b});
         chk("pulse count", 16'(model_u.pulses), (i == 1) ? 16'd3 : 16'd1);
      end
      model_u.prog_fails = 30;
      model_u.pulses = 0;
      op(3'h1, 16'h0000, 8'h00, {3'b001, 8'h00, shadow[0]});
      chk("pulse limit", 16'(model_u.pulses), 16'd25);
      for (int i = 0; i < 4; i++) op(3'h0, 16'(i), 8'h00, {11'h000, shadow[i]});
      // Codes 4 to 7 all act as reset
      for (int o = 4; o < 8; o++)
      begin
         op(3'(o), 16'(o), 8'h00, 19'h40000);
         chk("mode after reset", {13'h0, model_u.st}, 16'h0000);
      end
      model_u.erase_fails = 1;
      op(3'h2, 16'h0000, 8'h00, 19'h000ff);
      chk("erase left", 16'(model_u.erase_fails), 16'h0000);
      for (int i = 0; i < 4; i++) op(3'h0, 16'(i), 8'h00, 19'h000ff);
      chk("vpp idle", {15'h0, vpp}, 16'h0000);
      stop_test();
   end
endmodule
